//--- hw/hbcs_top.sv
// Serial command decode, fault latching and status reply for a twelve-channel
// half-bridge driver. Assumes fault inputs are asynchronous levels and that
// the serial clock stands still outside frames.
//
// Notes on behaviour
// - Command bit 15 set clears faults of the group that bit 14 selects.
// - Latched faults clear on reset request; a fault still present stays latched.
// - Bit 14 one steers the word to channels 12-7, zero to 6-1.
// - Bit 13 lets an underload shut down its own channel in the selected group.
// - Bits 12-7 enable the group's six bridges, zero leaves output floating.
// - Bits 6-1 pick high side on (one) or low side on (zero).
// - Bit 0 enables global overvoltage lockout, whatever group is selected.
// - All stored command bits of both groups are zero after reset.
// - Reply reports the group selected by the previously accepted command.
// - Thermal shutdown goes out before bit 15; thermal warning is bit 0.
// - Bit 14 is one whenever a load supply is under or over voltage.
// - Bits 12-1 hold two-bit states, highest channel in bits 12:11.
// - State codes: 00 disabled, 01 overcurrent, 10 underload, 11 enabled.
// - At frame end a word is taken only if the clock count was valid.
// - Thermal shutdown bit drives serial out from select low to first clock.
// - Enable low clears all command, fault and snapshot storage and turns every driver off.
// - Status bits 15, 13 and 12-1 are zero after reset; bits 14 and 0 follow the fault inputs.
`timescale 1ns/100ps
`default_nettype none

module hbcs_top
  import hbcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic chip_select_low_i,
  input wire logic serial_in_i,
  input wire logic enable_i,
  input wire hbcs_fault_t fault_i,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  output logic [NUM_CH-1:0] high_side_switch_o,
  output logic [NUM_CH-1:0] low_side_switch_o,
  output logic thermal_shutdown_flag_o,
  output logic channel_group_select_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Link domain on the serial clock.
  logic lk_started_q;
  logic lk_tog_q;
  logic lk_tog_d;
  logic lk_ok_q;
  logic lk_ok_d;
  logic [4:0] lk_cnt_q;
  logic [4:0] lk_cnt_d;
  logic [CMD_W-1:0] lk_rx_q;
  logic [CMD_W-1:0] lk_rx_d;
  logic [CMD_W-1:0] lk_tx_q;
  logic [CMD_W-1:0] lk_tx_d;
  logic [CMD_W-1:0] snap_q;
  logic tsd_q;
  wire lk_frame_rst = rst_i | chip_select_low_i;

  always_ff @(posedge sclk_i or posedge lk_frame_rst) begin
    if (lk_frame_rst) begin
      lk_started_q <= 1'b0;
    end else begin
      lk_started_q <= 1'b1;
    end
  end

  wire [4:0] lk_cnt_inc = 5'(lk_cnt_q + 5'h01);
  wire [4:0] lk_cnt_step = (lk_cnt_q == FRAME_WRAP) ? FRAME_GOOD : lk_cnt_inc;

  always_comb begin
    lk_cnt_d = lk_started_q ? lk_cnt_step : FRAME_FIRST;
    lk_ok_d = (lk_cnt_d == FRAME_GOOD);
    lk_rx_d = {lk_rx_q[CMD_W-2:0], serial_in_i};
    lk_tx_d = lk_started_q ? {lk_tx_q[CMD_W-2:0], serial_in_i} : snap_q;
    lk_tog_d = lk_started_q ? lk_tog_q : ~lk_tog_q;
  end

  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      lk_cnt_q <= 5'h00;
      lk_ok_q <= 1'b0;
      lk_rx_q <= CMD_RESET;
      lk_tx_q <= ST_RESET;
      lk_tog_q <= 1'b0;
    end else begin
      lk_cnt_q <= lk_cnt_d;
      lk_ok_q <= lk_ok_d;
      lk_rx_q <= lk_rx_d;
      lk_tx_q <= lk_tx_d;
      lk_tog_q <= lk_tog_d;
    end
  end

  // Shutdown flag is ORed with the serial input so it also ripples down a chain.
  assign serial_out_o = lk_started_q ? lk_tx_q[CMD_W-1] : (tsd_q | serial_in_i);
  assign serial_out_oe_o = ~chip_select_low_i;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers into the system clock.
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  logic en_s1_q;
  logic en_s2_q;
  logic tog_s1_q;
  logic tog_s2_q;
  logic tog_seen_q;
  hbcs_fault_t flt_s1_q;
  hbcs_fault_t flt_s2_q;

  always_ff @(posedge clk_i) begin
    cs_s1_q <= chip_select_low_i;
    cs_s2_q <= cs_s1_q;
    cs_s3_q <= cs_s2_q;
    en_s1_q <= enable_i;
    en_s2_q <= en_s1_q;
    tog_s1_q <= lk_tog_q;
    tog_s2_q <= tog_s1_q;
    flt_s1_q <= fault_i;
    flt_s2_q <= flt_s1_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame acceptance and command decode.
  wire clr = rst_i | ~en_s2_q;
  wire cs_rise = cs_s2_q & ~cs_s3_q;
  wire cs_fall = ~cs_s2_q & cs_s3_q;
  wire clocked = tog_s2_q != tog_seen_q;
  // Receive word and length flag are still while the serial clock stands.
  wire accept = cs_rise & clocked & lk_ok_q;
  wire [CMD_W-1:0] word = lk_rx_q;
  wire word_sel = word[CMD_SEL];
  wire status_reset_request = accept & word[CMD_SRR];
  wire srr_hi = status_reset_request & word_sel;
  wire srr_lo = status_reset_request & ~word_sel;

  logic [CMD_W-1:0] high_group_command_word_q;
  logic [CMD_W-1:0] low_group_command_word_q;
  logic overvoltage_lockout_enable_q;
  logic rep_sel_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tog_seen_q <= 1'b0;
    end else if (cs_rise) begin
      tog_seen_q <= tog_s2_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (clr) begin
      high_group_command_word_q <= CMD_RESET;
      low_group_command_word_q <= CMD_RESET;
      overvoltage_lockout_enable_q <= 1'b0;
      rep_sel_q <= 1'b0;
    end else if (accept) begin
      if (word_sel) begin
        high_group_command_word_q <= word & CMD_STORE_MASK;
      end else begin
        low_group_command_word_q <= word & CMD_STORE_MASK;
      end
      overvoltage_lockout_enable_q <= word[CMD_OVERVOLTAGE_LOCKOUT_ENABLE];
      rep_sel_q <= word_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Global faults.
  wire supply_fault_flag = flt_s2_q.uv | flt_s2_q.ov;
  wire supply_block = flt_s2_q.uv | (flt_s2_q.ov & overvoltage_lockout_enable_q);
  wire tsd_d = (tsd_q & ~status_reset_request) | flt_s2_q.thermal_shutdown_flag;

  always_ff @(posedge clk_i) begin
    if (clr) begin
      tsd_q <= 1'b0;
    end else begin
      tsd_q <= tsd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel latches, drive and state fields.
  logic [NUM_CH-1:0] ocs_q;
  logic [NUM_CH-1:0] uld_q;
  logic [NUM_CH-1:0] hs_q;
  logic [NUM_CH-1:0] ls_q;
  logic [NUM_CH-1:0][1:0] bridge_state_field_w;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    localparam int K = c % GRP_CH;
    wire in_hi = (c >= GRP_CH);
    wire [CMD_W-1:0] cmd = in_hi ? high_group_command_word_q : low_group_command_word_q;
    wire srr_g = in_hi ? srr_hi : srr_lo;
    wire ocs_d = (ocs_q[c] & ~srr_g) | flt_s2_q.oc[c];
    wire uld_d = (uld_q[c] & ~srr_g) | flt_s2_q.ul[c];
    wire en = cmd[CMD_EN_LO+K];
    wire side = cmd[CMD_SIDE_LO+K];
    wire uld_stop = uld_q[c] & cmd[CMD_UNDERLOAD_SHUTDOWN_CONTROL];
    wire drive = en & ~ocs_q[c] & ~uld_stop & ~tsd_q & ~supply_block;
    wire hs_d = drive & side;
    wire ls_d = drive & ~side;

    // Overcurrent outranks underload, which outranks plain enable.
    assign bridge_state_field_w[c] = ocs_q[c] ? BRIDGE_STATE_FIELD_OCS :
                       uld_q[c] ? BRIDGE_STATE_FIELD_ULD :
                       en ? BRIDGE_STATE_FIELD_ON : BRIDGE_STATE_FIELD_OFF;

    always_ff @(posedge clk_i) begin
      if (clr) begin
        ocs_q[c] <= 1'b0;
        uld_q[c] <= 1'b0;
        hs_q[c] <= 1'b0;
        ls_q[c] <= 1'b0;
      end else begin
        ocs_q[c] <= ocs_d;
        uld_q[c] <= uld_d;
        hs_q[c] <= hs_d;
        ls_q[c] <= ls_d;
      end
    end
  end

  assign high_side_switch_o = hs_q;
  assign low_side_switch_o = ls_q;
  assign thermal_shutdown_flag_o = tsd_q;
  assign channel_group_select_o = rep_sel_q;

  ////////////////////////////////////////////////////////////////////////////
  // Status words and the snapshot handed to the link.
  wire [CMD_W-1:0] high_group_status_word = {
    |ocs_q[NUM_CH-1:GRP_CH],
    supply_fault_flag,
    |uld_q[NUM_CH-1:GRP_CH],
    bridge_state_field_w[NUM_CH-1:GRP_CH],
    flt_s2_q.tw
  };
  wire [CMD_W-1:0] low_group_status_word = {
    |ocs_q[GRP_CH-1:0],
    supply_fault_flag,
    |uld_q[GRP_CH-1:0],
    bridge_state_field_w[GRP_CH-1:0],
    flt_s2_q.tw
  };
  wire [CMD_W-1:0] report =
    rep_sel_q ? high_group_status_word : low_group_status_word;

  // Snapshot is taken on select low, well before the first serial clock edge.
  always_ff @(posedge clk_i) begin
    if (clr) begin
      snap_q <= ST_RESET;
    end else if (cs_fall) begin
      snap_q <= report;
    end
  end

endmodule

`default_nettype wire

//--- hw/hbcs_pkg.sv
// Constants and types for the half-bridge command and status word block.
// Assumes a 16-bit serial frame, MSB first, and twelve channels in two groups.
package hbcs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes.
  localparam int CMD_W = 16;
  localparam int GRP_CH = 6;
  localparam int NUM_CH = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Command word fields.
  localparam int CMD_SRR = 15;
  localparam int CMD_SEL = 14;
  localparam int CMD_UNDERLOAD_SHUTDOWN_CONTROL = 13;
  localparam int CMD_EN_LO = 7;
  localparam int CMD_SIDE_LO = 1;
  localparam int CMD_OVERVOLTAGE_LOCKOUT_ENABLE = 0;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [15:0] CMD_STORE_MASK = 16'h7fff;

  ////////////////////////////////////////////////////////////////////////////
  // Status word fields.
  localparam int ST_OCS = 15;
  localparam int ST_PSF = 14;
  localparam int ST_ULD = 13;
  localparam int ST_FIELD_LO = 1;
  localparam int ST_TW = 0;
  localparam logic [15:0] ST_RESET = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel state field codes.
  localparam logic [1:0] BRIDGE_STATE_FIELD_OFF = 2'h0;
  localparam logic [1:0] BRIDGE_STATE_FIELD_OCS = 2'h1;
  localparam logic [1:0] BRIDGE_STATE_FIELD_ULD = 2'h2;
  localparam logic [1:0] BRIDGE_STATE_FIELD_ON = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Frame length checking: first word 16 clocks, then steps of 8.
  localparam logic [4:0] FRAME_FIRST = 5'h01;
  localparam logic [4:0] FRAME_GOOD = 5'h10;
  localparam logic [4:0] FRAME_WRAP = 5'h17;

  ////////////////////////////////////////////////////////////////////////////
  // Fault inputs from the analog protection circuits.
  typedef struct packed {
    logic thermal_shutdown_flag;
    logic tw;
    logic uv;
    logic ov;
    logic [NUM_CH-1:0] oc;
    logic [NUM_CH-1:0] ul;
  } hbcs_fault_t;

endpackage

//--- dv/hbcs_sva.sv
// Pin checks for the half-bridge command and status block.
// Assumes it is bound to hbcs_top.
`timescale 1ns/100ps
`default_nettype none
module hbcs_sva
  import hbcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic chip_select_low_i,
  input wire logic serial_in_i,
  input wire logic enable_i,
  input wire hbcs_fault_t fault_i,
  input wire logic serial_out_o,
  input wire logic serial_out_oe_o,
  input wire logic [NUM_CH-1:0] high_side_switch_o,
  input wire logic [NUM_CH-1:0] low_side_switch_o,
  input wire logic thermal_shutdown_flag_o,
  input wire logic channel_group_select_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic off = !(|high_side_switch_o) && !(|low_side_switch_o);
  sequence s_tsd;
    (fault_i.thermal_shutdown_flag && enable_i) [*4];
  endsequence
  sequence s_uv;
    (fault_i.uv && enable_i) [*5];
  endsequence
  oe_pin_a: assert property (serial_out_oe_o == !chip_select_low_i)
    else $error("output enable wrong");
  lead_bit_a: assert property ($fell(chip_select_low_i) |->
    serial_out_o == (thermal_shutdown_flag_o | serial_in_i)) else $error("lead bit wrong");
  side_excl_a: assert property (!(|(high_side_switch_o & low_side_switch_o)))
    else $error("both sides on");
  reset_clr_a: assert property ($past(rst_i) |-> off && !thermal_shutdown_flag_o)
    else $error("not clear after reset");
  enable_clr_a: assert property (!enable_i [*5] |-> off && !channel_group_select_o)
    else $error("not clear with enable low");
  tsd_latch_a: assert property (s_tsd |-> thermal_shutdown_flag_o)
    else $error("thermal flag missing");
  supply_off_a: assert property (s_uv |-> off)
    else $error("drivers on in undervoltage");
  group_hold_a: assert property ($changed(channel_group_select_o) |-> chip_select_low_i)
    else $error("group moved in frame");
  tsd_clear_a: assert property ($fell(thermal_shutdown_flag_o) |-> chip_select_low_i)
    else $error("thermal flag cleared in frame");
endmodule
bind hbcs_top hbcs_sva i_sva (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk_i),
  .chip_select_low_i(chip_select_low_i), .serial_in_i(serial_in_i), .enable_i(enable_i),
  .fault_i(fault_i), .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o),
  .high_side_switch_o(high_side_switch_o), .low_side_switch_o(low_side_switch_o),
  .thermal_shutdown_flag_o(thermal_shutdown_flag_o),
  .channel_group_select_o(channel_group_select_o));
`default_nettype wire

//--- dv/hbcs_master.sv
// Serial bus master model with a 6 ns link clock.
// Assumes released lines sit at their bias levels.
`timescale 1ns/100ps
`default_nettype none
module hbcs_master (
  output logic sclk_o,
  output logic csn_o,
  output logic si_o,
  input wire logic so_i
);
  initial begin
    sclk_o = 1'b0;
    csn_o = 1'b1;
    si_o = 1'b0;
  end
  // Frame of n clocks with the command in the last 16 bits.
  task automatic xfer(input logic [15:0] cmd, input int n, output logic [15:0] st,
      output logic pre);
    logic [31:0] w;
    w = {16'h0000, cmd};
    st = 16'h0000;
    csn_o = 1'b0;
    #150;
    pre = so_i;
    for (int k = n - 1; k >= 0; k--) begin
      si_o = w[k];
      #3 sclk_o = 1'b1;
      #2 st = {st[14:0], so_i};
      #1 sclk_o = 1'b0;
    end
    si_o = 1'b0;
    #20 csn_o = 1'b1;
    #300;
  endtask
endmodule
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the half-bridge command and status block.
// Assumes the master model drives the serial side.
`timescale 1ns/100ps
`default_nettype none
module tb
  import hbcs_pkg::*;
;
  logic clk_i;
  logic rst_i;
  logic enable_i;
  hbcs_fault_t flt;
  wire logic sclk, csn, si, so, oe, so_w, thermal_shutdown_flag, grp;
  wire logic [NUM_CH-1:0] hs, ls;
  logic [15:0] st;
  logic pre;
  int n_mismatch;
  int checks;
  assign so_w = oe ? so : 1'bz;
  hbcs_master i_m (.sclk_o(sclk), .csn_o(csn), .si_o(si), .so_i(so_w));
  hbcs_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .chip_select_low_i(csn),
    .serial_in_i(si), .enable_i(enable_i), .fault_i(flt), .serial_out_o(so),
    .serial_out_oe_o(oe), .high_side_switch_o(hs), .low_side_switch_o(ls),
    .thermal_shutdown_flag_o(thermal_shutdown_flag), .channel_group_select_o(grp));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic fr(input logic [15:0] c, input int n);
    i_m.xfer(c, n, st, pre);
  endtask
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_cfg();
    fr(16'h0000, 16);
    chk("st", 24'h0, {8'h00, st});
    chk("sw", 24'h0, {ls, hs});
    fr(16'h1fd4, 16);
    chk("sw", {6'h00, 6'h15, 6'h00, 6'h2a}, {ls, hs});
    fr(16'h5840, 24);
    chk("sw", {6'h10, 6'h15, 6'h20, 6'h2a}, {ls, hs});
    chk("grp", 24'h1, {23'h0, grp});
    fr(16'h5840, 16);
    chk("st", 24'h1e00, {8'h00, st});
    fr(16'h0000, 15);
    chk("sw", {6'h10, 6'h15, 6'h20, 6'h2a}, {ls, hs});
    fr(16'h1fd4, 16);
    chk("st", 24'h1e00, {8'h00, st});
  endtask
  task automatic t_sup();
    w(1);
    flt.uv <= 1'b1;
    w(6);
    chk("sw", 24'h0, {ls, hs});
    flt.uv <= 1'b0;
    flt.ov <= 1'b1;
    w(6);
    chk("sw", {6'h10, 6'h15, 6'h20, 6'h2a}, {ls, hs});
    fr(16'h1fd5, 16);
    chk("st", 24'h5ffe, {8'h00, st});
    chk("sw", 24'h0, {ls, hs});
    w(1);
    flt.ov <= 1'b0;
  endtask
  task automatic t_oc();
    w(1);
    flt.oc[0] <= 1'b1;
    w(4);
    flt.oc[0] <= 1'b0;
    w(4);
    chk("sw", {6'h10, 6'h14, 6'h20, 6'h2a}, {ls, hs});
    fr(16'h1fd4, 16);
    chk("st", 24'h9ffa, {8'h00, st});
    fr(16'h9fd4, 16);
    chk("sw", {6'h10, 6'h15, 6'h20, 6'h2a}, {ls, hs});
  endtask
  task automatic t_tsd();
    w(1);
    flt.thermal_shutdown_flag <= 1'b1;
    flt.tw <= 1'b1;
    w(5);
    flt.thermal_shutdown_flag <= 1'b0;
    fr(16'h1fd4, 16);
    chk("pre", 24'h1, {23'h0, pre});
    chk("st", 24'h1fff, {8'h00, st});
    chk("sw", 24'h0, {ls, hs});
    fr(16'h9fd4, 16);
    chk("tsd", 24'h0, {23'h0, thermal_shutdown_flag});
    chk("sw", {6'h10, 6'h15, 6'h20, 6'h2a}, {ls, hs});
  endtask
  task automatic t_ul();
    w(1);
    flt.ul[11] <= 1'b1;
    w(4);
    flt.ul[11] <= 1'b0;
    w(4);
    chk("sw", {6'h10, 6'h15, 6'h20, 6'h2a}, {ls, hs});
    fr(16'h7840, 16);
    chk("st", 24'h1fff, {8'h00, st});
    chk("sw", {6'h10, 6'h15, 6'h00, 6'h2a}, {ls, hs});
    fr(16'h7840, 16);
    chk("st", 24'h3601, {8'h00, st});
  endtask
  task automatic t_en();
    w(1);
    enable_i <= 1'b0;
    flt <= '0;
    w(6);
    chk("sw", 24'h0, {ls, hs});
    enable_i <= 1'b1;
    w(4);
    fr(16'h0000, 16);
    chk("st", 24'h0, {8'h00, st});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    n_mismatch = 0;
    checks = 0;
    rst_i = 1'b1;
    enable_i = 1'b1;
    flt = '0;
    w(5);
    rst_i <= 1'b0;
    w(4);
    t_cfg();
    t_sup();
    t_oc();
    t_tsd();
    t_ul();
    t_en();
    close_out();
  end
  initial begin
    #100us;
    n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
